// File: verilog/clk_seq_pkg.sv
// Constants for the display PLL clock sequencer.
// Assumes one 125 MHz system clock; reference selection comes from a strap port.
package clk_seq_pkg;
  localparam int CLK_MHZ = 125;
  // Reference selection codes
  localparam logic [1:0] REF_19P2 = 2'h0;
  localparam logic [1:0] REF_24 = 2'h1;
  localparam logic [1:0] REF_38P4 = 2'h2;
  // Core clock frequency selection codes
  localparam logic [2:0] CDF_LOW = 3'h0;
  localparam logic [2:0] CDF_192 = 3'h1;
  localparam logic [2:0] CDF_MID = 3'h2;
  localparam logic [2:0] CDF_HALF = 3'h3;
  localparam logic [2:0] CDF_HIGH = 3'h4;
  localparam logic [2:0] CDF_TOP = 3'h5;
  localparam logic [1:0] DOUBLE_RATE_CORE_CLOCK_DIV1 = 2'h1;
  localparam logic [1:0] DOUBLE_RATE_CORE_CLOCK_DIV2 = 2'h2;
  localparam logic [7:0] RATIO_BYPASS = 8'h00;
  // PLL timing limits
  localparam int LOCK_TIME_NS = 50000;
  localparam int UNLOCK_TIME_NS = 1000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * CLK_MHZ) / 1000;
  localparam int UNLOCK_CYC = (UNLOCK_TIME_NS * CLK_MHZ) / 1000;
  localparam int LOCK_W = 16;
  // Escape divisor M is in 8X cycles; 1X divisor is ceiling(M/8)
  localparam int ESC_M_W = 8;
  localparam int ESC_SHIFT = 3;
  localparam logic [ESC_M_W-1:0] ESC_ROUND = 8'h07;
  localparam int NUM_PLL = 5;
  localparam int UNAVAIL_PLL = 3;
  localparam int TUNNEL_PLL = 2;
  // Oscillator integers for a 24 MHz reference
  localparam logic [9:0] OSC_INT_A = 10'h151;
  localparam logic [14:0] OSC_FRAC_A = 15'h4000;
  localparam logic [9:0] OSC_INT_B = 10'h168;
  localparam logic [9:0] OSC_INT_C = 10'h195;
  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_PWR = 3'b001,
    S_LOCKING = 3'b010,
    S_LOCKED = 3'b011,
    S_UNLOCKING = 3'b100
  } pll_state_t;
endpackage

// File: verilog/display_pll_clock_sequencer.sv
// Display PLL clock sequencer: core clock ratio select, PLL power/lock status per PLL,
// and the DSI byte-clock side: escape emulation, receive escape clock, fifo inlet.
// Assumes software follows the enable/disable sequences and never retunes a live PLL.
`timescale 1ns/1ps
// How it works
// RQ1 - Ratio/divider pairs for 19.2, 38.4 references
// RQ2 - Ratio/divider pairs for 24 MHz reference
// RQ3 - Core-clock control crosses into byte clock
// RQ4 - Byte clock moves one byte per lane
// RQ5 - LP transmit changes only at escape rate
// RQ6 - Escape divide N equals ceiling of M/8
// RQ7 - Receive escape clock is XOR of lines
// RQ8 - Forwarded byte data absorbed by inlet fifo
// RQ9 - PLL is 8X; fixed 4X/1X, variable escape
// RQ10 - Software never retunes an enabled PLL
// RQ11 - Power state asserts at once after enable
// RQ12 - Software reads config back before enabling
// RQ13 - Software runs voltage switching around changes
// RQ14 - Lock reported within 50 microseconds
// RQ15 - Software maps port before ungating it
// RQ16 - Unlock within 1 microsecond, power drops
// RQ17 - Software uses listed 24 MHz oscillator values
// RQ18 - PLL four unavailable, PLL three tunnelling
// RQ19 - Two-port variants use first two PLLs
// RQ20 - Bypass core clock is reference halved
// RQ21 - Core freq is ref times ratio over 2*div
module display_pll_clock_sequencer #(
  parameter int LOCK_CYCLES = clk_seq_pkg::LOCK_CYC,
  parameter int UNLOCK_CYCLES = clk_seq_pkg::UNLOCK_CYC,
  parameter int LANES = 4
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] REF_SEL_I,
  input wire logic CD_PLL_EN_I,
  input wire logic [2:0] CD_FREQ_SEL_I,
  output logic [7:0] CD_RATIO_O,
  output logic [1:0] CD_DIV_O,
  output logic CD_BYPASS_O,
  input wire logic [clk_seq_pkg::NUM_PLL-1:0] PLL_POWER_EN_I,
  input wire logic [clk_seq_pkg::NUM_PLL-1:0] PLL_EN_I,
  output logic [clk_seq_pkg::NUM_PLL-1:0] PLL_POWER_STATE_O,
  output logic [clk_seq_pkg::NUM_PLL-1:0] PLL_LOCK_O,
  output logic [clk_seq_pkg::NUM_PLL-1:0] PLL_AVAILABLE_O,
  input wire logic [clk_seq_pkg::ESC_M_W-1:0] ESC_DIV_M_I,
  input wire logic [1:0] LP_TX_I,
  output logic [1:0] LP_TX_O,
  output logic ESC_TICK_O,
  input wire logic [1:0] LP_RX_I,
  output logic RX_ESC_CLK_O,
  input wire logic [LANES*8-1:0] HS_BYTES_I,
  input wire logic HS_VALID_I,
  output logic [LANES*8-1:0] HS_BYTES_O,
  output logic HS_VALID_O
);
  localparam int CNT_W = clk_seq_pkg::LOCK_W;
  logic [7:0] ratio_next;
  logic [1:0] div_next;
  logic [clk_seq_pkg::ESC_M_W-1:0] esc_n;
  logic [clk_seq_pkg::ESC_M_W:0] esc_sum;
  logic [clk_seq_pkg::ESC_M_W-1:0] esc_cnt_reg;
  logic [LANES*8-1:0] inlet_reg [2];
  logic [1:0] inlet_vld_reg;
  logic inlet_wr_reg;
  logic inlet_rd_reg;

  // RQ1 RQ2 ratio table
  always_comb begin
    ratio_next = clk_seq_pkg::RATIO_BYPASS;
    div_next = clk_seq_pkg::DOUBLE_RATE_CORE_CLOCK_DIV1;
    if (REF_SEL_I == clk_seq_pkg::REF_24) begin
      unique case (CD_FREQ_SEL_I)
        clk_seq_pkg::CDF_LOW: ratio_next = 8'h0F;
        clk_seq_pkg::CDF_192: ratio_next = 8'h10;
        clk_seq_pkg::CDF_MID: ratio_next = 8'h1A;
        clk_seq_pkg::CDF_HALF: begin
          ratio_next = 8'h36;
          div_next = clk_seq_pkg::DOUBLE_RATE_CORE_CLOCK_DIV2;
        end
        clk_seq_pkg::CDF_HIGH: ratio_next = 8'h2E;
        clk_seq_pkg::CDF_TOP: ratio_next = 8'h36;
        default: ratio_next = clk_seq_pkg::RATIO_BYPASS;
      endcase
    end else begin
      unique case (CD_FREQ_SEL_I)
        clk_seq_pkg::CDF_LOW: ratio_next = 8'h12;
        clk_seq_pkg::CDF_192: ratio_next = 8'h14;
        clk_seq_pkg::CDF_MID: ratio_next = 8'h20;
        clk_seq_pkg::CDF_HALF: begin
          ratio_next = 8'h44;
          div_next = clk_seq_pkg::DOUBLE_RATE_CORE_CLOCK_DIV2;
        end
        clk_seq_pkg::CDF_HIGH: ratio_next = 8'h3A;
        clk_seq_pkg::CDF_TOP: ratio_next = 8'h44;
        default: ratio_next = clk_seq_pkg::RATIO_BYPASS;
      endcase
      // 38.4 reference uses half the 19.2 ratio
      if (REF_SEL_I == clk_seq_pkg::REF_38P4) begin
        ratio_next = {1'b0, ratio_next[7:1]};
      end
    end
  end

  // RQ20 RQ21 bypass when PLL off
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CD_RATIO_O <= clk_seq_pkg::RATIO_BYPASS;
      CD_DIV_O <= clk_seq_pkg::DOUBLE_RATE_CORE_CLOCK_DIV1;
      CD_BYPASS_O <= 1'b1;
    end else begin
      CD_RATIO_O <= CD_PLL_EN_I ? ratio_next : clk_seq_pkg::RATIO_BYPASS;
      CD_DIV_O <= CD_PLL_EN_I ? div_next : clk_seq_pkg::DOUBLE_RATE_CORE_CLOCK_DIV1;
      CD_BYPASS_O <= ~CD_PLL_EN_I;
    end
  end

  genvar g;
  generate
    for (g = 0; g < clk_seq_pkg::NUM_PLL; g++) begin : g_pll
      clk_seq_pkg::pll_state_t state_reg;
      logic [CNT_W-1:0] cnt_reg;
      // RQ18 fourth PLL unavailable
      localparam bit USABLE = (g != clk_seq_pkg::UNAVAIL_PLL);
      assign PLL_AVAILABLE_O[g] = USABLE;
      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          state_reg <= clk_seq_pkg::S_OFF;
          cnt_reg <= '0;
        end else if (!USABLE) begin
          state_reg <= clk_seq_pkg::S_OFF;
          cnt_reg <= '0;
        end else begin
          unique case (state_reg)
            // RQ11 power state immediate
            clk_seq_pkg::S_OFF: if (PLL_POWER_EN_I[g]) state_reg <= clk_seq_pkg::S_PWR;
            clk_seq_pkg::S_PWR: begin
              cnt_reg <= '0;
              if (!PLL_POWER_EN_I[g]) state_reg <= clk_seq_pkg::S_OFF;
              else if (PLL_EN_I[g]) state_reg <= clk_seq_pkg::S_LOCKING;
            end
            // RQ14 lock within bound
            clk_seq_pkg::S_LOCKING: begin
              cnt_reg <= cnt_reg + 1'b1;
              if (!PLL_EN_I[g]) state_reg <= clk_seq_pkg::S_PWR;
              else if (cnt_reg >= CNT_W'(LOCK_CYCLES - 1)) begin
                state_reg <= clk_seq_pkg::S_LOCKED;
              end
            end
            clk_seq_pkg::S_LOCKED: begin
              cnt_reg <= '0;
              if (!PLL_EN_I[g]) state_reg <= clk_seq_pkg::S_UNLOCKING;
            end
            // RQ16 unlock within bound
            clk_seq_pkg::S_UNLOCKING: begin
              cnt_reg <= cnt_reg + 1'b1;
              if (cnt_reg >= CNT_W'(UNLOCK_CYCLES - 1)) state_reg <= clk_seq_pkg::S_PWR;
            end
            default: state_reg <= clk_seq_pkg::S_OFF;
          endcase
        end
      end
      assign PLL_POWER_STATE_O[g] = (state_reg != clk_seq_pkg::S_OFF);
      assign PLL_LOCK_O[g] = (state_reg == clk_seq_pkg::S_LOCKED) ||
                             (state_reg == clk_seq_pkg::S_UNLOCKING);
    end
  endgenerate

  // RQ6 ceiling of M over 8, never below one
  always_comb begin
    // One spare bit so that the rounding add cannot wrap for large M
    esc_sum = {1'b0, ESC_DIV_M_I} + {1'b0, clk_seq_pkg::ESC_ROUND};
    esc_n = clk_seq_pkg::ESC_M_W'(esc_sum >> clk_seq_pkg::ESC_SHIFT);
    if (esc_n == '0) esc_n = 8'h01;
  end

  // RQ5 RQ9 escape emulated from byte clock
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      esc_cnt_reg <= '0;
      ESC_TICK_O <= 1'b0;
    end else if (esc_cnt_reg >= esc_n - 1'b1) begin
      esc_cnt_reg <= '0;
      ESC_TICK_O <= 1'b1;
    end else begin
      esc_cnt_reg <= esc_cnt_reg + 1'b1;
      ESC_TICK_O <= 1'b0;
    end
  end

  // RQ5 LP lines change on tick only
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) LP_TX_O <= 2'h3;
    else if (ESC_TICK_O) LP_TX_O <= LP_TX_I;
  end

  // RQ7 receive escape XOR
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) RX_ESC_CLK_O <= 1'b0;
    else RX_ESC_CLK_O <= LP_RX_I[0] ^ LP_RX_I[1];
  end

  // RQ3 RQ4 RQ8 two-entry inlet fifo absorbs phase slip
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      inlet_wr_reg <= 1'b0;
      inlet_rd_reg <= 1'b0;
      inlet_vld_reg <= 2'h0;
      HS_BYTES_O <= '0;
      HS_VALID_O <= 1'b0;
    end else begin
      if (HS_VALID_I) begin
        inlet_reg[inlet_wr_reg] <= HS_BYTES_I;
        inlet_wr_reg <= ~inlet_wr_reg;
      end
      inlet_vld_reg <= {inlet_vld_reg[0], HS_VALID_I};
      HS_VALID_O <= inlet_vld_reg[1];
      if (inlet_vld_reg[1]) begin
        HS_BYTES_O <= inlet_reg[inlet_rd_reg];
        inlet_rd_reg <= ~inlet_rd_reg;
      end
    end
  end
endmodule

// File: bench/clk_seq_properties.sv
// Checker for port relations of the display PLL clock sequencer.
// Assumes a bind onto the top module; PLL 0 carries the sequence traffic.
`timescale 1ns/1ps
module clk_seq_checker #(
  parameter int LOCK_CYCLES = 8,
  parameter int UNLOCK_CYCLES = 4
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CD_PLL_EN_I,
  input wire logic [7:0] CD_RATIO_O,
  input wire logic CD_BYPASS_O,
  input wire logic [4:0] PLL_POWER_EN_I,
  input wire logic [4:0] PLL_EN_I,
  input wire logic [4:0] PLL_POWER_STATE_O,
  input wire logic [4:0] PLL_LOCK_O,
  input wire logic [4:0] PLL_AVAILABLE_O,
  input wire logic [1:0] LP_TX_O,
  input wire logic ESC_TICK_O,
  input wire logic [1:0] LP_RX_I,
  input wire logic RX_ESC_CLK_O,
  input wire logic [31:0] HS_BYTES_I,
  input wire logic HS_VALID_I,
  input wire logic [31:0] HS_BYTES_O,
  input wire logic HS_VALID_O
);
  // Two cycles of slack: one for the state step before counting starts, one spare
  localparam int LOCK_MAX = LOCK_CYCLES + 2;
  localparam int UNLOCK_MAX = UNLOCK_CYCLES + 2;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_lock_req; $rose(PLL_EN_I[0]) && PLL_POWER_STATE_O[0]; endsequence
  sequence s_lock_seen; ##[1:LOCK_MAX] PLL_LOCK_O[0]; endsequence
  sequence s_unlock_req; $fell(PLL_EN_I[0]) && PLL_LOCK_O[0]; endsequence
  property p_lock; s_lock_req |-> s_lock_seen; endproperty
  property p_early; $rose(PLL_LOCK_O[0]) |-> $past(PLL_EN_I[0], LOCK_CYCLES); endproperty
  property p_unlock; s_unlock_req |-> ##[1:UNLOCK_MAX] !PLL_LOCK_O[0]; endproperty
  property p_pwr; $rose(PLL_POWER_EN_I[0]) |=> PLL_POWER_STATE_O[0]; endproperty
  property p_pll3; !PLL_POWER_STATE_O[3] && PLL_AVAILABLE_O == 5'h17; endproperty
  property p_bypass; !CD_PLL_EN_I |=> CD_BYPASS_O && CD_RATIO_O == 8'h00; endproperty
  property p_lptx; !$past(RST_I) && !$past(ESC_TICK_O) |-> $stable(LP_TX_O); endproperty
  property p_rx; !$past(RST_I) |-> RX_ESC_CLK_O == ($past(LP_RX_I[0]) ^ $past(LP_RX_I[1]));
  endproperty
  property p_hs; HS_VALID_I |-> ##3 HS_VALID_O && HS_BYTES_O == $past(HS_BYTES_I, 3); endproperty
  a_lock: assert property (p_lock) else $error("lock late");
  a_early: assert property (p_early) else $error("lock early");
  a_unlock: assert property (p_unlock) else $error("unlock late");
  a_pwr: assert property (p_pwr) else $error("power state late");
  a_pll3: assert property (p_pll3) else $error("pll map wrong");
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  a_lptx: assert property (p_lptx) else $error("lp tx off tick");
  a_rx: assert property (p_rx) else $error("rx escape wrong");
  a_hs: assert property (p_hs) else $error("byte path wrong");
endmodule

// File: bench/test_display_pll_clock_sequencer.sv
// Self-checking bench for the display PLL clock sequencer.
// Assumes short lock counts; inputs move 1 ns after each rising edge.
`timescale 1ns/1ps
module test_display_pll_clock_sequencer;
  logic CLK_I = 0, RST_I = 1, CD_PLL_EN_I = 1, HS_VALID_I = 0, ESC_TICK_O, RX_ESC_CLK_O;
  logic [1:0] REF_SEL_I = 0, LP_TX_I = 0, LP_RX_I = 0, LP_TX_O, CD_DIV_O;
  logic [2:0] CD_FREQ_SEL_I = 0;
  logic [4:0] PLL_POWER_EN_I = 0, PLL_EN_I = 0, PLL_POWER_STATE_O, PLL_LOCK_O, PLL_AVAILABLE_O;
  logic [7:0] ESC_DIV_M_I = 8'h08, CD_RATIO_O;
  logic [31:0] HS_BYTES_I = 0, HS_BYTES_O;
  logic CD_BYPASS_O, HS_VALID_O;
  int err_total = 0, n_compared = 0, r, f, n;
  // Rows: ratio for 19.2 MHz, ratio for 24 MHz; 38.4 MHz takes half the first
  logic [15:0] rows [6] = '{16'h120F, 16'h1410, 16'h201A, 16'h4436, 16'h3A2E, 16'h4436};
  display_pll_clock_sequencer #(.LOCK_CYCLES(8), .UNLOCK_CYCLES(4)) dut (.*);
  always #4 CLK_I = ~CLK_I;
  task automatic cyc(int k = 1);
    repeat (k) @(posedge CLK_I);
    #1;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    results();
  end
  initial begin
    cyc(8);
    RST_I = 0;
    for (r = 0; r < 3; r++) for (f = 0; f < 6; f++) begin
      REF_SEL_I = r[1:0];
      CD_FREQ_SEL_I = f[2:0];
      cyc(2);
      chk("ratio", CD_RATIO_O, r == 1 ? rows[f][7:0] : r == 0 ? rows[f][15:8] : rows[f][15:9]);
      chk("div", CD_DIV_O, f == 3 ? 2 : 1);
    end
    CD_FREQ_SEL_I = 3'h6;
    cyc(2);
    chk("bad code", CD_RATIO_O, 0);
    CD_PLL_EN_I = 0;
    cyc(2);
    chk("bypass", {CD_BYPASS_O, CD_RATIO_O}, 9'h100);
    PLL_POWER_EN_I = 5'h1F;
    cyc(2);
    chk("power", PLL_POWER_STATE_O, 5'h17);
    chk("available", PLL_AVAILABLE_O, 5'h17);
    PLL_EN_I = 5'h01;
    n = 0;
    while (PLL_LOCK_O[0] !== 1'b1 && n < 40) begin cyc(); n++; end
    chk("lock time", n >= 8 && n <= 10, 1);
    // Power drop while locked must wait for unlock
    PLL_POWER_EN_I = 5'h00;
    cyc(2);
    chk("held power", PLL_POWER_STATE_O[0], 1);
    PLL_EN_I = 0;
    n = 0;
    while (PLL_LOCK_O[0] !== 1'b0 && n < 40) begin cyc(); n++; end
    chk("unlock time", n <= 6, 1);
    cyc(3);
    chk("power off", PLL_POWER_STATE_O, 0);
    LP_TX_I = 2'h1;
    HS_VALID_I = 1;
    for (r = 0; r < 3; r++) begin
      ESC_DIV_M_I = r == 0 ? 8'h08 : r == 1 ? 8'h09 : 8'h11;
      HS_BYTES_I = {4{ESC_DIV_M_I}};
      LP_RX_I = r[1:0];
      LP_TX_I = r[1:0] + 2'h1;
      cyc(4);
      n = 0;
      while (ESC_TICK_O !== 1'b1 && n < 20) begin cyc(); n++; end
      n = 0;
      do begin cyc(); n++; end while (ESC_TICK_O !== 1'b1 && n < 20);
      chk("escape period", n, r + 1);
      chk("lp tx", LP_TX_O, LP_TX_I);
      chk("rx escape", RX_ESC_CLK_O, LP_RX_I[0] ^ LP_RX_I[1]);
      chk("hs bytes", {HS_VALID_O, HS_BYTES_O}, {1'b1, HS_BYTES_I});
    end
    PLL_POWER_EN_I = 5'h01;
    cyc(2);
    RST_I = 1;
    cyc();
    chk("reset", {CD_RATIO_O, CD_DIV_O, CD_BYPASS_O, PLL_POWER_STATE_O, LP_TX_O}, 18'h00183);
    RST_I = 0;
    cyc(2);
    chk("power after reset", PLL_POWER_STATE_O, 5'h01);
    results();
  end
endmodule
bind display_pll_clock_sequencer clk_seq_checker #(.LOCK_CYCLES(LOCK_CYCLES),
  .UNLOCK_CYCLES(UNLOCK_CYCLES)) chk_i (.*);
